// >>> logic/actc_defines.vh
// Purpose: constants of the conversion timing control block
// Assumes: 200 MHz system clock, 4.096 MHz nominal converter clock
// Notes: conversion counts are in converter clock periods
`ifndef ACTC_DEFINES_VH
`define ACTC_DEFINES_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ACTC_OFS_CTRL 5'h00
`define ACTC_OFS_EXC 5'h04
`define ACTC_OFS_CMD 5'h08
`define ACTC_OFS_STATUS 5'h0c
`define ACTC_OFS_COUNT 5'h10

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define ACTC_CTRL_MODE 1:0
`define ACTC_CTRL_RATE 4:2
`define ACTC_CTRL_CONT 5
`define ACTC_CTRL_REF 7:6
`define ACTC_EXC_LEVEL 2:0
`define ACTC_EXC_RTA 5:3
`define ACTC_EXC_RTB 8:6
`define ACTC_CMD_START 0
`define ACTC_CMD_SLEEP 1
`define ACTC_CMD_RESET 2
`define ACTC_CTRL_RST 8'h00
`define ACTC_EXC_RST 9'h000
`define ACTC_REF_INTERNAL 2'h0
`define ACTC_MODE_NORMAL 2'h0
`define ACTC_MODE_DUTY 2'h1
`define ACTC_MODE_TURBO 2'h2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define ACTC_CLK_NS 5
`define ACTC_OSC_WAKE_NS 50000
`define ACTC_OSC_WAKE_TURBO_NS 25000
`define ACTC_REF_SETTLE_NS 25000
`define ACTC_IDAC_SETTLE_NS 200000
`define ACTC_PHASE_STEP 32'h053e2d62
`define ACTC_START_DLY_NORMAL 20'h000d2
`define ACTC_START_DLY_TURBO 20'h00072
`define ACTC_MOD_DIV_NORMAL 4'hf
`define ACTC_MOD_DIV_TURBO 4'h7
`define ACTC_CN_0 20'd204768
`define ACTC_CN_1 20'd91120
`define ACTC_CN_2 20'd46128
`define ACTC_CN_3 20'd23664
`define ACTC_CN_4 20'd12464
`define ACTC_CN_5 20'd6896
`define ACTC_CN_6 20'd4144
`define ACTC_SN_0 20'd204850
`define ACTC_SN_1 20'd91218
`define ACTC_SN_2 20'd46226
`define ACTC_SN_3 20'd23762
`define ACTC_SN_4 20'd12562
`define ACTC_SN_5 20'd6994
`define ACTC_SN_6 20'd4242
`define ACTC_CD_0 20'd823120
`define ACTC_CD_1 20'd364560
`define ACTC_CD_2 20'd184592
`define ACTC_CD_3 20'd94736
`define ACTC_CD_4 20'd49936
`define ACTC_CD_5 20'd27664
`define ACTC_CD_6 20'd16656
`define ACTC_CT_0 20'd102384
`define ACTC_CT_1 20'd45560
`define ACTC_CT_2 20'd23064
`define ACTC_CT_3 20'd11832
`define ACTC_CT_4 20'd6232
`define ACTC_CT_5 20'd3448
`define ACTC_CT_6 20'd2072
`define ACTC_ST_0 20'd102434
`define ACTC_ST_1 20'd45618
`define ACTC_ST_2 20'd23122
`define ACTC_ST_3 20'd11890
`define ACTC_ST_4 20'd6290
`define ACTC_ST_5 20'd3506
`define ACTC_ST_6 20'd2130

`endif

// >>> logic/actc_core.v
// Purpose: conversion timing, clock source, reference and excitation control
// Assumes: commands from a serial decoder on sys_clk, or from the cmd register
// Notes: conversion periods count converter clock ticks, not sys_clk cycles
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "actc_defines.vh"

module actc_core
#(
	parameter OSC_WAKE_CYC = `ACTC_OSC_WAKE_NS / `ACTC_CLK_NS,
	parameter OSC_WAKE_TURBO_CYC = `ACTC_OSC_WAKE_TURBO_NS / `ACTC_CLK_NS,
	parameter REF_SETTLE_CYC = `ACTC_REF_SETTLE_NS / `ACTC_CLK_NS,
	parameter IDAC_SETTLE_CYC = `ACTC_IDAC_SETTLE_NS / `ACTC_CLK_NS
)
(
	// clock, reset, enable
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	// avalon-mm slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// command strobes from the serial decoder
	input wire start_first_edge,
	input wire start_last_edge,
	input wire sleep_cmd,
	input wire reset_cmd,
	// clock pin
	input wire ext_clk_pin,
	// analog control outputs
	output reg conversion_done_n,
	output reg osc_enable,
	output reg use_ext_clk,
	output reg modulator_tick,
	output reg [1:0] ref_select,
	output reg ref_ready,
	output reg [2:0] excitation_current_level,
	output reg [2:0] excitation_route_a,
	output reg [2:0] excitation_route_b,
	output reg idac_bias_en,
	output reg idac_ready
);

	// -----------------------------------------------------------------
	// states
	// -----------------------------------------------------------------
	localparam ST_IDLE = 4'b0001;
	localparam ST_WAKE = 4'b0010;
	localparam ST_DELAY = 4'b0100;
	localparam ST_CONV = 4'b1000;

	// -----------------------------------------------------------------
	// period tables
	// -----------------------------------------------------------------
	function [19:0] cont_period;
		input [1:0] mode;
		input [2:0] rate;
		begin
			case ({(mode == 2'h3) ? `ACTC_MODE_NORMAL : mode, rate}) // code 3 acts as normal
				5'h00: cont_period = `ACTC_CN_0;
				5'h01: cont_period = `ACTC_CN_1;
				5'h02: cont_period = `ACTC_CN_2;
				5'h03: cont_period = `ACTC_CN_3;
				5'h04: cont_period = `ACTC_CN_4;
				5'h05: cont_period = `ACTC_CN_5;
				5'h08: cont_period = `ACTC_CD_0;
				5'h09: cont_period = `ACTC_CD_1;
				5'h0a: cont_period = `ACTC_CD_2;
				5'h0b: cont_period = `ACTC_CD_3;
				5'h0c: cont_period = `ACTC_CD_4;
				5'h0d: cont_period = `ACTC_CD_5;
				5'h0e, 5'h0f: cont_period = `ACTC_CD_6;
				5'h10: cont_period = `ACTC_CT_0;
				5'h11: cont_period = `ACTC_CT_1;
				5'h12: cont_period = `ACTC_CT_2;
				5'h13: cont_period = `ACTC_CT_3;
				5'h14: cont_period = `ACTC_CT_4;
				5'h15: cont_period = `ACTC_CT_5;
				5'h16, 5'h17: cont_period = `ACTC_CT_6;
				default: cont_period = `ACTC_CN_6;
			endcase
		end
	endfunction

	// duty mode falls through to the normal column
	function [19:0] single_period;
		input [1:0] mode;
		input [2:0] rate;
		begin
			case ({mode == `ACTC_MODE_TURBO, rate})
				4'h0: single_period = `ACTC_SN_0;
				4'h1: single_period = `ACTC_SN_1;
				4'h2: single_period = `ACTC_SN_2;
				4'h3: single_period = `ACTC_SN_3;
				4'h4: single_period = `ACTC_SN_4;
				4'h5: single_period = `ACTC_SN_5;
				4'h8: single_period = `ACTC_ST_0;
				4'h9: single_period = `ACTC_ST_1;
				4'ha: single_period = `ACTC_ST_2;
				4'hb: single_period = `ACTC_ST_3;
				4'hc: single_period = `ACTC_ST_4;
				4'hd: single_period = `ACTC_ST_5;
				4'he, 4'hf: single_period = `ACTC_ST_6;
				default: single_period = `ACTC_SN_6;
			endcase
		end
	endfunction

	// byte-lane merge for register writes
	function [31:0] be_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer i;
		begin
			be_merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					be_merge[i*8 +: 8] = wd[i*8 +: 8];
		end
	endfunction

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	reg [7:0] ctrl;
	reg [8:0] exc;
	reg ack;
	reg pin_s1, pin_s2, pin_s3;
	reg [1:0] edge_cnt;
	reg [31:0] phase;
	reg tick;
	reg osc_ready;
	reg [13:0] osc_cnt;
	reg [12:0] ref_cnt;
	reg [15:0] idac_cnt;
	reg asleep;
	reg [3:0] state;
	reg [19:0] conv_cnt;
	reg [3:0] mod_cnt;
	reg [15:0] done_count;
	wire [1:0] mode = ctrl[`ACTC_CTRL_MODE];
	wire [2:0] rate = ctrl[`ACTC_CTRL_RATE];
	wire cont = ctrl[`ACTC_CTRL_CONT];
	wire turbo = (mode == `ACTC_MODE_TURBO);
	wire wr_go = avs_write & ~ack & clk_en;
	// merged words are cut back to the register width on purpose
	wire [31:0] next_ctrl_word = be_merge({24'h000000, ctrl}, avs_writedata, avs_byteenable);
	wire [31:0] next_exc_word = be_merge({23'h000000, exc}, avs_writedata, avs_byteenable);
	wire rd_go = avs_read & ~ack & clk_en;
	wire wr_cmd = wr_go & (avs_address == `ACTC_OFS_CMD) & avs_byteenable[0];
	wire go_begin = start_first_edge | (wr_cmd & avs_writedata[`ACTC_CMD_START]);
	wire go_end = start_last_edge | (wr_cmd & avs_writedata[`ACTC_CMD_START]);
	wire go_sleep = sleep_cmd | (wr_cmd & avs_writedata[`ACTC_CMD_SLEEP]);
	wire go_reset = reset_cmd | (wr_cmd & avs_writedata[`ACTC_CMD_RESET]);
	wire clk_ok = use_ext_clk | osc_ready;
	wire [13:0] wake_len = turbo ? OSC_WAKE_TURBO_CYC[13:0] : OSC_WAKE_CYC[13:0];
	wire rd_status = rd_go & (avs_address == `ACTC_OFS_STATUS);
	wire [31:0] status_word = {24'h000000, ~asleep, idac_bias_en, idac_ready,
		ref_ready, use_ext_clk, osc_ready, ~state[0], ~conversion_done_n};

	// -----------------------------------------------------------------
	// avalon slave: one wait state on every access
	// -----------------------------------------------------------------
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;

	// ack and read data register
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			ack <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else if (clk_en)
		begin
			ack <= (avs_read | avs_write) & ~ack;
			if (rd_go)
			begin
				case (avs_address)
					`ACTC_OFS_CTRL: avs_readdata <= {24'h000000, ctrl};
					`ACTC_OFS_EXC: avs_readdata <= {23'h000000, exc};
					`ACTC_OFS_STATUS: avs_readdata <= status_word;
					`ACTC_OFS_COUNT: avs_readdata <= {16'h0000, done_count};
					default: avs_readdata <= 32'h00000000; // unmapped reads zero
				endcase
			end
		end
	end

	// configuration registers; reset command restores defaults too
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			ctrl <= `ACTC_CTRL_RST;
			exc <= `ACTC_EXC_RST;
		end
		else if (clk_en)
		begin
			if (go_reset)
			begin
				ctrl <= `ACTC_CTRL_RST;
				exc <= `ACTC_EXC_RST;
			end
			else if (wr_go && avs_address == `ACTC_OFS_CTRL)
				ctrl <= next_ctrl_word[7:0];
			else if (wr_go && avs_address == `ACTC_OFS_EXC)
				exc <= next_exc_word[8:0];
		end
	end

	// -----------------------------------------------------------------
	// clock source: synchroniser, edge count, tick generator
	// -----------------------------------------------------------------
	// pin_s1 feeds only pin_s2; edges are taken from s2 and s3
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			pin_s1 <= 1'b0;
			pin_s2 <= 1'b0;
			pin_s3 <= 1'b0;
			edge_cnt <= 2'h0;
			use_ext_clk <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_s1 <= ext_clk_pin;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			if (go_reset)
			begin
				edge_cnt <= 2'h0;
				use_ext_clk <= 1'b0;
			end
			else if (pin_s2 & ~pin_s3 & ~use_ext_clk)
			begin
				edge_cnt <= edge_cnt + 2'h1;
				if (edge_cnt == 2'h1)
					use_ext_clk <= 1'b1;
			end
		end
	end

	// one tick per converter clock period; rates follow the source
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			phase <= 32'h00000000;
			tick <= 1'b0;
		end
		else if (clk_en)
		begin
			if (use_ext_clk)
				tick <= pin_s2 & ~pin_s3;
			else if (osc_ready)
			begin
				{tick, phase} <= {1'b0, phase} + {1'b0, `ACTC_PHASE_STEP};
			end
			else
				tick <= 1'b0;
		end
	end

	// oscillator power and wake-up timer
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			osc_enable <= 1'b0;
			osc_ready <= 1'b0;
			osc_cnt <= 14'h0000;
		end
		else if (clk_en)
		begin
			if (use_ext_clk || go_sleep || go_reset)
			begin
				osc_enable <= 1'b0;
				osc_ready <= 1'b0;
				osc_cnt <= 14'h0000;
			end
			else if (go_begin && !osc_enable)
			begin
				osc_enable <= 1'b1;
				osc_cnt <= wake_len;
			end
			else if (osc_enable && !osc_ready)
			begin
				if (osc_cnt <= 14'h0001)
					osc_ready <= 1'b1;
				osc_cnt <= osc_cnt - 14'h0001;
			end
			else if (state[0] && !cont && osc_ready && !go_begin)
			begin
				// oscillator idles between single-shot conversions
				osc_enable <= 1'b0;
				osc_ready <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// reference and excitation sources
	// -----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			ref_select <= `ACTC_REF_INTERNAL;
			ref_ready <= 1'b0;
			ref_cnt <= REF_SETTLE_CYC[12:0];
			asleep <= 1'b0;
		end
		else if (clk_en)
		begin
			ref_select <= ctrl[`ACTC_CTRL_REF];
			if (go_sleep)
				asleep <= 1'b1;
			else if (go_begin || go_reset)
				asleep <= 1'b0;
			// restart settling on wake or on a switch back to internal
			if (go_sleep || (asleep && go_begin) || go_reset ||
				(ctrl[`ACTC_CTRL_REF] == `ACTC_REF_INTERNAL &&
				ref_select != `ACTC_REF_INTERNAL))
			begin
				ref_ready <= 1'b0;
				ref_cnt <= REF_SETTLE_CYC[12:0];
			end
			else if (!asleep && !ref_ready)
			begin
				if (ref_cnt <= 13'h0001)
					ref_ready <= 1'b1;
				ref_cnt <= ref_cnt - 13'h0001;
			end
		end
	end

	// sources power down on sleep, keep running between single shots
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			excitation_current_level <= 3'h0;
			excitation_route_a <= 3'h0;
			excitation_route_b <= 3'h0;
			idac_bias_en <= 1'b0;
			idac_ready <= 1'b0;
			idac_cnt <= 16'h0000;
		end
		else if (clk_en)
		begin
			excitation_current_level <= asleep ? 3'h0 : exc[`ACTC_EXC_LEVEL];
			excitation_route_a <= exc[`ACTC_EXC_RTA];
			excitation_route_b <= exc[`ACTC_EXC_RTB];
			idac_bias_en <= ~asleep & (exc[`ACTC_EXC_LEVEL] != 3'h0);
			if (asleep || exc[`ACTC_EXC_LEVEL] == 3'h0 ||
				exc[`ACTC_EXC_LEVEL] != excitation_current_level)
			begin
				idac_ready <= 1'b0;
				idac_cnt <= IDAC_SETTLE_CYC[15:0];
			end
			else if (!idac_ready)
			begin
				if (idac_cnt <= 16'h0001)
					idac_ready <= 1'b1;
				idac_cnt <= idac_cnt - 16'h0001;
			end
		end
	end

	// -----------------------------------------------------------------
	// conversion sequencer
	// -----------------------------------------------------------------
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			state <= ST_IDLE;
			conv_cnt <= 20'h00000;
			conversion_done_n <= 1'b1;
			done_count <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (rd_status)
				conversion_done_n <= 1'b1; // result taken
			if (go_sleep || go_reset)
				state <= ST_IDLE;
			else if (go_end)
			begin
				conversion_done_n <= 1'b1;
				state <= ST_WAKE;
			end
			else
			begin
				case (state)
					ST_IDLE: state <= ST_IDLE;
					ST_WAKE:
					begin
						if (clk_ok)
						begin
							if (cont)
							begin
								conv_cnt <= turbo ? `ACTC_START_DLY_TURBO :
									`ACTC_START_DLY_NORMAL;
								state <= ST_DELAY;
							end
							else
							begin
								conv_cnt <= single_period(mode, rate);
								state <= ST_CONV;
							end
						end
					end
					ST_DELAY:
					begin
						if (tick)
						begin
							if (conv_cnt == 20'h00001)
							begin
								conv_cnt <= cont_period(mode, rate);
								state <= ST_CONV;
							end
							else
								conv_cnt <= conv_cnt - 20'h00001;
						end
					end
					ST_CONV:
					begin
						if (tick)
						begin
							if (conv_cnt == 20'h00002 && cont)
								conversion_done_n <= 1'b1; // rise so the next fall is seen
							if (conv_cnt == 20'h00001)
							begin
								conversion_done_n <= 1'b0;
								done_count <= done_count + 16'h0001;
								if (cont)
									conv_cnt <= cont_period(mode, rate);
								else
									state <= ST_IDLE;
							end
							else
								conv_cnt <= conv_cnt - 20'h00001;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// modulator tick: converter clock divided by 16, or 8 in turbo
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			mod_cnt <= 4'h0;
			modulator_tick <= 1'b0;
		end
		else if (clk_en)
		begin
			modulator_tick <= 1'b0;
			if (!state[3] && !state[2])
				mod_cnt <= 4'h0;
			else if (tick)
			begin
				if (mod_cnt >= (turbo ? `ACTC_MOD_DIV_TURBO : `ACTC_MOD_DIV_NORMAL))
				begin
					mod_cnt <= 4'h0;
					modulator_tick <= 1'b1;
				end
				else
					mod_cnt <= mod_cnt + 4'h1;
			end
		end
	end

endmodule // actc_core

// >>> testbench/actc_core_props.sv
// Purpose: port checks of actc_core
// Assumes: one clock domain, synchronous active high reset
// Notes: attached by the bind at the foot
`timescale 1ns/1ps
`include "actc_defines.vh"

module actc_core_props
#(
	parameter OSC_WAKE_CYC = 20,
	parameter OSC_WAKE_TURBO_CYC = 20,
	parameter REF_SETTLE_CYC = 20,
	parameter IDAC_SETTLE_CYC = 20
)
(
	// clock and control
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	// bus
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// commands and clock pin
	input wire start_first_edge,
	input wire start_last_edge,
	input wire sleep_cmd,
	input wire reset_cmd,
	input wire ext_clk_pin,
	// analog controls
	input wire conversion_done_n,
	input wire osc_enable,
	input wire use_ext_clk,
	input wire modulator_tick,
	input wire [1:0] ref_select,
	input wire ref_ready,
	input wire [2:0] excitation_current_level,
	input wire [2:0] excitation_route_a,
	input wire [2:0] excitation_route_b,
	input wire idac_bias_en,
	input wire idac_ready
);
	reg pin_q = 1'b0;
	reg [1:0] pin_rises = 2'h0;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	// raw pin rises; the design sees them later, never sooner
	always @(posedge sys_clk)
	begin
		pin_q <= ext_clk_pin;
		if (reset || reset_cmd)
			pin_rises <= 2'h0;
		else if (ext_clk_pin && !pin_q && pin_rises != 2'h3)
			pin_rises <= pin_rises + 2'h1;
	end

	// ------
	// checks
	// ------
	a_reset_state: assert property ($fell(reset) |-> conversion_done_n && !use_ext_clk
		&& ref_select == 2'h0) else $error("bad state after reset");
	a_osc_wakes: assert property (start_first_edge && clk_en && !sleep_cmd && !reset_cmd
		&& !use_ext_clk |-> ##[1:2] osc_enable) else $error("oscillator not woken");
	a_two_edges: assert property ($rose(use_ext_clk) |-> pin_rises >= 2'h2)
		else $error("external clock taken too early");
	a_osc_off_ext: assert property (use_ext_clk |=> !osc_enable)
		else $error("oscillator left on");
	a_ext_sticky: assert property ($fell(use_ext_clk) |-> $past(reset_cmd)
		|| $past(avs_write)) else $error("left external clock");
	a_bias_level: assert property (excitation_current_level != 3'h0 |-> idac_bias_en)
		else $error("bias off with level set");
	a_sleep_off: assert property (sleep_cmd && clk_en |-> ##[1:2]
		(excitation_current_level == 3'h0 && !idac_bias_en)) else $error("sources on asleep");
	a_route_copy: assert property (avs_write && !avs_waitrequest && avs_byteenable == 4'hf
		&& avs_address == `ACTC_OFS_EXC |-> ##2 excitation_route_b == $past(avs_writedata[8:6], 2)
		&& excitation_route_a == $past(avs_writedata[5:3], 2)) else $error("route not copied");
	a_tick_gap: assert property (modulator_tick |=> !modulator_tick [*8])
		else $error("modulator ticks too close");
	a_done_holds: assert property ($fell(conversion_done_n) && !start_last_edge
		&& !reset_cmd && !sleep_cmd && !avs_read |=> !conversion_done_n)
		else $error("done pulse too short");

	// main scenarios
	c_done: cover property ($fell(conversion_done_n));
	c_ext: cover property ($rose(use_ext_clk));
	c_sleep: cover property (sleep_cmd);
endmodule // actc_core_props

bind actc_core actc_core_props #(.OSC_WAKE_CYC(OSC_WAKE_CYC),
	.OSC_WAKE_TURBO_CYC(OSC_WAKE_TURBO_CYC), .REF_SETTLE_CYC(REF_SETTLE_CYC),
	.IDAC_SETTLE_CYC(IDAC_SETTLE_CYC)) props_i (.sys_clk(sys_clk), .reset(reset),
	.clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.start_first_edge(start_first_edge), .start_last_edge(start_last_edge),
	.sleep_cmd(sleep_cmd), .reset_cmd(reset_cmd), .ext_clk_pin(ext_clk_pin),
	.conversion_done_n(conversion_done_n), .osc_enable(osc_enable),
	.use_ext_clk(use_ext_clk), .modulator_tick(modulator_tick), .ref_select(ref_select),
	.ref_ready(ref_ready), .excitation_current_level(excitation_current_level),
	.excitation_route_a(excitation_route_a), .excitation_route_b(excitation_route_b),
	.idac_bias_en(idac_bias_en), .idac_ready(idac_ready));

// >>> testbench/actc_host_model.sv
// Purpose: serial host and clock source facing actc_core
// Assumes: command frames already decoded to sys_clk pulses
// Notes: external clock is six sys_clk cycles a period
`timescale 1ns/1ps

module actc_host_model
(
	// clock
	input wire sys_clk,
	// command strobes
	output reg start_first_edge = 1'b0,
	output reg start_last_edge = 1'b0,
	output reg sleep_cmd = 1'b0,
	output reg reset_cmd = 1'b0,
	// clock pin
	output reg ext_clk_pin = 1'b0
);
	reg run = 1'b0;
	reg [2:0] ph = 3'h0;
	integer rises = 0;

	// pin grounded while stopped so the oscillator stays chosen
	always @(posedge sys_clk)
	begin
		ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
		ext_clk_pin <= run && (ph == 3'h5 || ph < 3'h2);
		if (run && ph == 3'h5)
			rises <= rises + 1;
	end

	// one sleep (1) or reset (2) pulse
	task send_cmd(input [1:0] which);
	begin
		@(posedge sys_clk);
		sleep_cmd <= (which == 2'h1);
		reset_cmd <= (which == 2'h2);
		@(posedge sys_clk);
		sleep_cmd <= 1'b0;
		reset_cmd <= 1'b0;
	end
	endtask

	// last edge lands mid-period so no tick straddles the start
	task send_start;
	begin
		@(posedge sys_clk);
		start_first_edge <= 1'b1;
		@(posedge sys_clk);
		start_first_edge <= 1'b0;
		while (run && ph != 3'h3)
			@(posedge sys_clk);
		start_last_edge <= 1'b1;
		@(posedge sys_clk);
		start_last_edge <= 1'b0;
	end
	endtask
endmodule // actc_host_model

// >>> testbench/tb.sv
// Purpose: self-checking bench of actc_core
// Assumes: 200 MHz sys_clk, host model gives commands and clock pin
// Notes: settle times cut to 20 cycles to keep the run short
`timescale 1ns/1ps
`include "actc_defines.vh"

`define CHK(what, want, got) \
	begin \
		checks_done = checks_done + 1; \
		if ((got) !== (want)) \
		begin \
			n_fail = n_fail + 1; \
			$display("unexpected %s: expected %0h, seen %0h", what, want, got); \
		end \
	end
`define WAIT(cond, lim) \
	n = 0; \
	while (!(cond) && n < (lim)) \
	begin \
		n = n + 1; \
		@(posedge sys_clk); \
	end

module tb;
	localparam SETTLE = 20;
	reg sys_clk = 1'b0;
	reg reset = 1'b1;
	reg clk_en = 1'b1;
	reg [4:0] avs_address = 5'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	reg [3:0] avs_byteenable = 4'hf;
	reg [31:0] rd;
	integer n, checks_done = 0, n_fail = 0, mod_ticks = 0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, start_first_edge, start_last_edge, sleep_cmd, reset_cmd, ext_clk_pin;
	wire conversion_done_n, osc_enable, use_ext_clk, modulator_tick, ref_ready;
	wire idac_bias_en, idac_ready;
	wire [1:0] ref_select;
	wire [2:0] excitation_current_level, excitation_route_a, excitation_route_b;

	// 200 MHz
	always #2.5 sys_clk = ~sys_clk;

	// modulator ticks seen, for the divider check
	always @(posedge sys_clk)
		if (modulator_tick === 1'b1)
			mod_ticks <= mod_ticks + 1;

	actc_host_model host (.sys_clk(sys_clk), .start_first_edge(start_first_edge),
		.start_last_edge(start_last_edge), .sleep_cmd(sleep_cmd), .reset_cmd(reset_cmd),
		.ext_clk_pin(ext_clk_pin));

	actc_core #(.OSC_WAKE_CYC(SETTLE), .OSC_WAKE_TURBO_CYC(SETTLE), .REF_SETTLE_CYC(SETTLE),
		.IDAC_SETTLE_CYC(SETTLE)) dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.start_first_edge(start_first_edge), .start_last_edge(start_last_edge),
		.sleep_cmd(sleep_cmd), .reset_cmd(reset_cmd), .ext_clk_pin(ext_clk_pin),
		.conversion_done_n(conversion_done_n), .osc_enable(osc_enable),
		.use_ext_clk(use_ext_clk), .modulator_tick(modulator_tick), .ref_select(ref_select),
		.ref_ready(ref_ready), .excitation_current_level(excitation_current_level),
		.excitation_route_a(excitation_route_a), .excitation_route_b(excitation_route_b),
		.idac_bias_en(idac_bias_en), .idac_ready(idac_ready));

	// ------
	// tasks
	// ------
	// one bus access, held until waitrequest is seen low
	task bus(input wr, input [4:0] addr, input [31:0] wdata);
	begin
		@(posedge sys_clk);
		avs_address <= addr;
		avs_writedata <= wdata;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		`WAIT(avs_waitrequest === 1'b0, 100)
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		`CHK("bus answer", 1'b0, avs_waitrequest)
	end
	endtask

	task t_reset_ref;
	begin
		bus(0, `ACTC_OFS_CTRL, 0);
		`CHK("ctrl reset", 32'h0, rd)
		bus(0, 5'h14, 0);
		`CHK("unmapped read", 32'h0, rd)
		`WAIT(ref_ready === 1'b1, SETTLE + 8)
		`CHK("ref after reset", 1'b1, ref_ready)
		bus(1, `ACTC_OFS_CTRL, 32'h80);
		repeat (2) @(posedge sys_clk);
		`CHK("ref select", 2'h2, ref_select)
		bus(1, `ACTC_OFS_CTRL, 32'h0);
		repeat (2) @(posedge sys_clk);
		`CHK("ref unsettled", 1'b0, ref_ready)
		`WAIT(ref_ready === 1'b1, SETTLE + 8)
		`CHK("ref settled", 1'b1, ref_ready)
		$display("test reset_ref done");
	end
	endtask

	task t_exc;
	begin
		bus(1, `ACTC_OFS_EXC, 32'h7);
		repeat (2) @(posedge sys_clk);
		`CHK("bias unrouted", 1'b1, idac_bias_en)
		`WAIT(idac_ready === 1'b1, SETTLE + 8)
		`CHK("idac settled", 1'b1, idac_ready)
		bus(1, `ACTC_OFS_EXC, 32'h1b7);
		repeat (2) @(posedge sys_clk);
		`CHK("shared route", 6'h36, {excitation_route_b, excitation_route_a})
		host.send_cmd(2'h1);
		repeat (2) @(posedge sys_clk);
		`CHK("level asleep", 3'h0, excitation_current_level)
		host.send_start;
		repeat (2) @(posedge sys_clk);
		`CHK("osc woken", 1'b1, osc_enable)
		host.run <= 1'b1;
		`WAIT(use_ext_clk === 1'b1, 40)
		`CHK("ext selected", 1'b1, use_ext_clk)
		$display("test exc_clock done");
	end
	endtask

	// single-shot count in pin ticks from start end to done fall
	task t_single(input [1:0] mode, input integer want);
		integer t0;
	begin
		bus(1, `ACTC_OFS_CTRL, {27'h0, 3'h6, mode});
		host.send_start;
		t0 = host.rises;
		`WAIT(conversion_done_n === 1'b0, want * 6 + 100)
		`CHK("single ticks", want, host.rises - t0)
		`CHK("level kept", 3'h7, excitation_current_level)
		bus(0, `ACTC_OFS_STATUS, 0);
		repeat (2) @(posedge sys_clk);
		`CHK("done released", 1'b1, conversion_done_n)
		$display("test single done");
	end
	endtask

	task t_cont;
		integer t0, m0;
	begin
		bus(1, `ACTC_OFS_CTRL, 32'h3a);
		host.send_start;
		t0 = host.rises;
		`WAIT(conversion_done_n === 1'b0, 30000)
		`CHK("first ticks", 114 + 2072, host.rises - t0)
		t0 = host.rises;
		m0 = mod_ticks;
		`WAIT(conversion_done_n === 1'b1, 15000)
		`WAIT(conversion_done_n === 1'b0, 15000)
		`CHK("period ticks", 2072, host.rises - t0)
		`CHK("modulator ticks", 2072 / 8, mod_ticks - m0)
		host.run <= 1'b0;
		repeat (6) @(posedge sys_clk);
		host.send_cmd(2'h2);
		repeat (3) @(posedge sys_clk);
		`CHK("back to osc", 1'b0, use_ext_clk)
		bus(0, `ACTC_OFS_COUNT, 0);
		`CHK("done count", 32'h4, rd)
		bus(1, `ACTC_OFS_CMD, 32'h1);
		@(posedge sys_clk);
		`CHK("osc woken by cmd", 1'b1, osc_enable)
		$display("test continuous done");
	end
	endtask

	task conclude;
	begin
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset_ref;
		t_exc;
		t_single(`ACTC_MODE_TURBO, 2130);
		t_single(`ACTC_MODE_DUTY, 4242);
		t_cont;
		conclude;
	end

	// hang guard, about 1.4 times the expected run
	initial
	begin
		#450000;
		n_fail = n_fail + 1;
		conclude;
	end
endmodule // tb
